// file: shc_pkg.sv
// shared constants and types for the synthesizer channel/hop control
// assumes a single 100 MHz core clock on both ends
package shc_pkg;
  localparam int FRAC_BITS = 19;
  localparam int TABLE_DEPTH = 64;
  localparam int TIDX_W = 6;
  localparam logic [7:0] SKIP_MARK = 8'hFF;
  localparam logic [7:0] CHAN_RESET = 8'h00;
  localparam logic [4:0] DIV_BAND0 = 5'h18;
  localparam logic [4:0] DIV_BAND1 = 5'h0C;
  localparam logic [4:0] DIV_BAND2 = 5'h0A;
  localparam logic [4:0] DIV_BAND3 = 5'h08;
  localparam logic [4:0] DIV_BAND4 = 5'h04;
  // timeouts in core cycles, counted from channel tune
  localparam int DWELL_NS = 10000;
  localparam int CLK_NS = 10;
  localparam logic [15:0] DWELL_CYCLES = 16'(DWELL_NS / CLK_NS);
  // host command codes
  localparam logic [3:0] CMD_NONE = 4'h0;
  localparam logic [3:0] CMD_SET_INT = 4'h1;
  localparam logic [3:0] CMD_SET_FRAC_HI = 4'h2;
  localparam logic [3:0] CMD_SET_FRAC_MID = 4'h3;
  localparam logic [3:0] CMD_SET_FRAC_LO = 4'h4;
  localparam logic [3:0] CMD_STEP_HI = 4'h5;
  localparam logic [3:0] CMD_STEP_LO = 4'h6;
  localparam logic [3:0] CMD_BAND = 4'h7;
  localparam logic [3:0] CMD_TABLE_SIZE = 4'h8;
  localparam logic [3:0] CMD_TABLE_ENTRY = 4'h9;
  localparam logic [3:0] CMD_HOP_CTRL = 4'hA;
  localparam logic [3:0] CMD_RSSI_LIMIT = 4'hB;
  localparam logic [3:0] CMD_START_RX = 4'hC;
  localparam logic [3:0] CMD_START_TX = 4'hD;
  localparam logic [3:0] CMD_IDLE = 4'hE;
  localparam logic [3:0] CMD_WAIT_LIMIT = 4'hF;
  // hop control bits
  localparam int HC_RSSI = 0;
  localparam int HC_PREAMBLE = 1;
  localparam int HC_SYNC = 2;
  localparam int HC_ENABLE = 3;
  localparam int HC_PKT = 4;
  localparam int HC_GPIO = 5;
  // host register offsets
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_FREQ = 4'h2;
  typedef enum logic [1:0] {MODE_IDLE, MODE_RX, MODE_TX} shc_mode_type;
endpackage

// file: shc_link_if.sv
// command link between host controller and synthesizer control
// assumes both ends clocked by core_clk
`timescale 1ns/1ns
`default_nettype none
interface shc_link_if;
  logic cmdValid;
  logic [3:0] cmdCode;
  logic [7:0] cmdData;
  logic [7:0] cmdIndex;
  logic chanGiven;
  logic [31:0] freqWord;
  logic [7:0] curChannel;
  logic [1:0] mode;
  modport dev (input cmdValid, cmdCode, cmdData, cmdIndex, chanGiven,
    output freqWord, curChannel, mode);
  modport host (output cmdValid, cmdCode, cmdData, cmdIndex, chanGiven,
    input freqWord, curChannel, mode);
endinterface
`default_nettype wire

// file: shc_hop_table.sv
// hop table storage plus skip search for the next used entry
// assumes writes and lookups come from the same clock domain
`timescale 1ns/1ns
`default_nettype none
module shc_hop_table
  import shc_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic arst_n, // async reset
  input wire logic wrEn, // write strobe
  input wire logic [shc_pkg::TIDX_W-1:0] wrIdx, // write index
  input wire logic [7:0] wrData, // channel number
  input wire logic [6:0] tableSize, // entries in use
  input wire logic [shc_pkg::TIDX_W-1:0] fromIdx, // current index
  output logic [shc_pkg::TIDX_W-1:0] nextIdx, // next used index
  output logic [7:0] nextChan, // its channel
  output logic wrapped // search passed end
);
  logic [7:0] mem [TABLE_DEPTH];
  // storage needs no reset; the host fills it before use
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrIdx] <= wrData;
    end
  end
  // combinational search; worst case walks the whole table once
  always_comb begin
    logic [6:0] idx;
    logic found;
    idx = 7'h00;
    found = 1'b0;
    nextIdx = fromIdx;
    nextChan = mem[fromIdx];
    wrapped = 1'b0;
    for (int k = 1; k <= TABLE_DEPTH; k++) begin
      idx = 7'(fromIdx) + 7'(k);
      if (tableSize != 7'h00 && idx >= tableSize) begin
        idx = idx - tableSize;
      end
      if (!found && 7'(k) <= tableSize && mem[idx[5:0]] != SKIP_MARK) begin
        found = 1'b1;
        nextIdx = idx[5:0];
        nextChan = mem[idx[5:0]];
        wrapped = (idx[5:0] <= fromIdx);
      end
    end
  end
endmodule
`default_nettype wire

// file: shc_synth_ctrl.sv
// device end: holds settings, forms the divider word, runs the hopper
// assumes modem status inputs are already on core_clk
`timescale 1ns/1ns
`default_nettype none
module shc_synth_ctrl
  import shc_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic arst_n, // async reset, low active
  shc_link_if.dev link, // host command link
  input wire logic [7:0] signalStrength, // instantaneous strength
  input wire logic preambleFound, // valid preamble seen
  input wire logic syncFound, // valid sync word seen
  input wire logic [15:0] txDeviation, // signed tx fraction offset
  output logic [7:0] integerDivideValue, // loop integer setting
  output logic [18:0] fractionDivideValue, // loop fraction, 19 bits
  output logic [4:0] outputDivider, // band divider
  output logic hopToggle // toggles per hop and wrap
);
  typedef struct packed {
    logic [7:0] intBase;
    logic [23:0] fracBase;
    logic [15:0] stepSize;
    logic [2:0] band;
    logic [6:0] tableSize;
    logic [5:0] hopCtrl;
    logic [7:0] sigLimit;
    logic [15:0] waitLimit;
    logic [7:0] channel;
    logic [TIDX_W-1:0] tIdx;
    shc_mode_type mode;
    logic [15:0] dwell;
    logic preSeen;
    logic stay;
    logic [7:0] intOut;
    logic [18:0] fracOut;
    logic [4:0] divOut;
    logic toggle;
    logic [31:0] freqWord;
  } shc_dev_state_type;

  shc_dev_state_type st, next_st;
  logic [TIDX_W-1:0] nIdx;
  logic [7:0] nChan;
  logic nWrap;
  logic [31:0] word;
  logic [31:0] stepProd;
  logic hopNow;
  logic tmoPre;
  logic tmoSync;

  shc_hop_table shc_hop_table_i (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .wrEn(link.cmdValid && link.cmdCode == CMD_TABLE_ENTRY),
    .wrIdx(link.cmdIndex[TIDX_W-1:0]),
    .wrData(link.cmdData),
    .tableSize(st.tableSize),
    .fromIdx(st.tIdx),
    .nextIdx(nIdx),
    .nextChan(nChan),
    .wrapped(nWrap)
  );

  // ------------------------------------------------------------
  // frequency word: the integer sits at bits 26:19
  // ------------------------------------------------------------
  always_comb begin
    stepProd = 32'(st.channel) * 32'(st.stepSize);
    // the whole fraction is added, so its one-to-two term carries
    word = {5'h00, st.intBase, 19'h00000} + 32'(st.fracBase) + stepProd;
    if (st.mode == MODE_TX) begin
      word = word + 32'(signed'(txDeviation));
    end
  end

  // ------------------------------------------------------------
  // hop decision
  // ------------------------------------------------------------
  always_comb begin
    // timeouts only usable with packet handling on
    tmoPre = st.hopCtrl[HC_PKT] && st.hopCtrl[HC_PREAMBLE] &&
      !st.preSeen && !preambleFound && st.dwell >= st.waitLimit;
    tmoSync = st.hopCtrl[HC_PKT] && st.hopCtrl[HC_SYNC] && st.preSeen &&
      !syncFound && st.dwell >= st.waitLimit;
    // raw strength compared each cycle, no filtering
    hopNow = !st.stay && (tmoPre || tmoSync ||
      (st.hopCtrl[HC_RSSI] && signalStrength < st.sigLimit));
  end

  always_comb begin
    next_st = st;
    next_st.freqWord = word;
    next_st.intOut = word[26:19];
    next_st.fracOut = word[18:0];
    case (st.band)
      3'h0: next_st.divOut = DIV_BAND0;
      3'h1: next_st.divOut = DIV_BAND1;
      3'h2: next_st.divOut = DIV_BAND2;
      3'h3: next_st.divOut = DIV_BAND3;
      default: next_st.divOut = DIV_BAND4;
    endcase
    if (st.mode == MODE_RX && st.dwell != 16'hFFFF) begin
      next_st.dwell = st.dwell + 16'h0001;
    end
    if (preambleFound) begin
      next_st.preSeen = 1'b1;
    end
    // first condition met settles the channel
    if (st.mode == MODE_RX && !st.stay) begin
      if (st.hopCtrl[HC_RSSI] && signalStrength >= st.sigLimit) begin
        next_st.stay = 1'b1;
      end else if (syncFound && st.preSeen) begin
        next_st.stay = 1'b1;
      end
    end
    if (st.mode == MODE_RX && st.hopCtrl[HC_ENABLE] && hopNow &&
        st.tableSize != 7'h00) begin
      next_st.tIdx = nIdx;
      next_st.channel = nChan;
      next_st.dwell = 16'h0000;
      next_st.preSeen = 1'b0;
      if (st.hopCtrl[HC_GPIO]) begin
        next_st.toggle = st.toggle ^ 1'b1 ^ nWrap;
        if (nWrap) begin
          next_st.toggle = st.toggle; // two toggles on wrap: hop + wrap
        end
      end
    end
    if (link.cmdValid) begin
      case (link.cmdCode)
        CMD_SET_INT: next_st.intBase = link.cmdData;
        CMD_SET_FRAC_HI: next_st.fracBase[23:16] = link.cmdData;
        CMD_SET_FRAC_MID: next_st.fracBase[15:8] = link.cmdData;
        CMD_SET_FRAC_LO: next_st.fracBase[7:0] = link.cmdData;
        CMD_STEP_HI: next_st.stepSize[15:8] = link.cmdData;
        CMD_STEP_LO: next_st.stepSize[7:0] = link.cmdData;
        CMD_BAND: next_st.band = link.cmdData[2:0];
        CMD_TABLE_SIZE: next_st.tableSize = (link.cmdData > 8'h40) ?
          7'h40 : link.cmdData[6:0];
        CMD_HOP_CTRL: next_st.hopCtrl = link.cmdData[5:0];
        CMD_RSSI_LIMIT: next_st.sigLimit = link.cmdData;
        CMD_WAIT_LIMIT: next_st.waitLimit = {link.cmdData, 8'h00};
        CMD_START_RX, CMD_START_TX: begin
          if (link.chanGiven) begin
            next_st.channel = link.cmdData;
          end
          next_st.mode = (link.cmdCode == CMD_START_RX) ? MODE_RX : MODE_TX;
          // hopping starts from entry zero on receive entry
          next_st.tIdx = '0;
          next_st.dwell = 16'h0000;
          next_st.preSeen = 1'b0;
          next_st.stay = 1'b0;
        end
        CMD_IDLE: next_st.mode = MODE_IDLE;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{intBase: 8'h00, fracBase: 24'h000000, stepSize: 16'h0000,
        band: 3'h0, tableSize: 7'h00, hopCtrl: 6'h00, sigLimit: 8'h00,
        waitLimit: DWELL_CYCLES, channel: CHAN_RESET, tIdx: '0,
        mode: MODE_IDLE, dwell: 16'h0000, preSeen: 1'b0, stay: 1'b0,
        intOut: 8'h00, fracOut: 19'h00000, divOut: DIV_BAND0,
        toggle: 1'b0, freqWord: 32'h00000000};
    end else begin
      st <= next_st;
    end
  end

  assign integerDivideValue = st.intOut;
  assign fractionDivideValue = st.fracOut;
  assign outputDivider = st.divOut;
  assign hopToggle = st.toggle;
  assign link.freqWord = st.freqWord;
  assign link.curChannel = st.channel;
  assign link.mode = st.mode;
endmodule
`default_nettype wire

// file: shc_host_ctrl.sv
// host end: software register port turned into link commands
// assumes software obeys one strobe per cycle
`timescale 1ns/1ns
`default_nettype none
module shc_host_ctrl
  import shc_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic arst_n, // async reset, low active
  shc_link_if.host link, // command link
  input wire logic [3:0] addr, // register address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata // read data, next cycle
);
  typedef struct packed {
    logic valid;
    logic [3:0] code;
    logic [7:0] data;
    logic [7:0] index;
    logic chanGiven;
    logic [31:0] rdata;
  } shc_host_state_type;

  shc_host_state_type st, next_st;

  // ------------------------------------------------------------
  // command register: {chanGiven, index, code, data} in one word
  // ------------------------------------------------------------
  // software must write fraction so the term lies in 1..2
  // step high then low byte limit and table before
  // start-receive at the first non-skip entry manual hop
  // calibration counts stay in software
  always_comb begin
    next_st = st;
    next_st.valid = 1'b0;
    next_st.rdata = 32'h00000000;
    if (wr && addr == REG_CMD) begin
      next_st.valid = 1'b1;
      next_st.data = wdata[7:0];
      next_st.code = wdata[11:8];
      next_st.index = wdata[19:12];
      next_st.chanGiven = wdata[20];
    end
    if (rd) begin
      case (addr)
        REG_STATUS: next_st.rdata = {22'h000000, link.mode, link.curChannel};
        REG_FREQ: next_st.rdata = link.freqWord;
        default: next_st.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{valid: 1'b0, code: CMD_NONE, data: 8'h00, index: 8'h00,
        chanGiven: 1'b0, rdata: 32'h00000000};
    end else begin
      st <= next_st;
    end
  end

  assign link.cmdValid = st.valid;
  assign link.cmdCode = st.code;
  assign link.cmdData = st.data;
  assign link.cmdIndex = st.index;
  assign link.chanGiven = st.chanGiven;
  assign rdata = st.rdata;
endmodule
`default_nettype wire

// file: shc_link_assertions.sv
// link checks between host end and device end
// assumes all link signals are on core_clk
`timescale 1ns/1ns
`default_nettype none
module shc_link_assertions
  import shc_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic arst_n, // async reset, low active
  input wire logic cmdValid, // command pulse
  input wire logic [3:0] cmdCode, // command code
  input wire logic [7:0] cmdData, // command data
  input wire logic chanGiven, // channel argument present
  input wire logic [31:0] freqWord, // divider word
  input wire logic [7:0] curChannel, // current channel
  input wire logic [1:0] mode // radio mode
);
  // ----
  // properties
  // ----
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_rx_entry: assert property (cmdValid && cmdCode == CMD_START_RX |->
    ##2 mode == MODE_RX) else $error("receive mode not entered");
  a_tx_entry: assert property (cmdValid && cmdCode == CMD_START_TX |->
    ##2 mode == MODE_TX) else $error("transmit mode not entered");
  a_idle_entry: assert property (cmdValid && cmdCode == CMD_IDLE |->
    ##2 mode == MODE_IDLE) else $error("idle mode not entered");
  a_chan_arg: assert property (cmdValid && cmdCode == CMD_START_TX &&
    chanGiven |-> ##2 curChannel == $past(cmdData, 2))
    else $error("channel argument not applied");
  a_chan_keep: assert property (cmdValid && cmdCode == CMD_START_TX &&
    !chanGiven && mode != MODE_RX |->
    ##2 curChannel == $past(curChannel, 2)) else $error("channel lost");
  a_reset_state: assert property ($rose(arst_n) |->
    curChannel == CHAN_RESET && mode == MODE_IDLE)
    else $error("bad state after reset");
  // outside receive mode only a command may move the channel
  a_hop_in_rx: assert property ($changed(curChannel) |->
    mode == MODE_RX || $past(cmdValid)) else $error("stray hop");
  a_skip_mark: assert property (mode == MODE_RX && $changed(curChannel) &&
    !$past(cmdValid) |-> curChannel != SKIP_MARK)
    else $error("hop landed on skip entry");
  a_freq_hold: assert property ($changed(freqWord) && mode == MODE_IDLE
    |-> $past(cmdValid) || $past(cmdValid, 2))
    else $error("frequency moved in idle");
endmodule
`default_nettype wire

// file: synth_channel_hop_control_test.sv
// self-checking bench: host end and device end joined by the link
// assumes software port and modem inputs are driven here
`timescale 1ns/1ns
`default_nettype none
module synth_channel_hop_control_test;
  import shc_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [7:0] signalStrength = 8'h00;
  logic preambleFound = 1'b0;
  logic syncFound = 1'b0;
  logic [15:0] txDeviation = 16'h0000;
  logic [7:0] integerDivideValue;
  logic [18:0] fractionDivideValue;
  logic [4:0] outputDivider;
  logic hopToggle;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  shc_link_if link();
  shc_host_ctrl shc_host_ctrl_i (.core_clk(core_clk), .arst_n(arst_n),
    .link(link), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));
  shc_synth_ctrl shc_synth_ctrl_i (.core_clk(core_clk), .arst_n(arst_n),
    .link(link), .signalStrength(signalStrength),
    .preambleFound(preambleFound), .syncFound(syncFound),
    .txDeviation(txDeviation), .integerDivideValue(integerDivideValue),
    .fractionDivideValue(fractionDivideValue),
    .outputDivider(outputDivider), .hopToggle(hopToggle));
  shc_link_assertions shc_link_assertions_i (.core_clk(core_clk),
    .arst_n(arst_n), .cmdValid(link.cmdValid), .cmdCode(link.cmdCode),
    .cmdData(link.cmdData), .chanGiven(link.chanGiven),
    .freqWord(link.freqWord), .curChannel(link.curChannel),
    .mode(link.mode));
  // ----
  // helpers
  // ----
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compared %0d, wrong %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // every task is entered just after a rising edge and leaves on one
  task automatic cmd(input logic [3:0] c, input logic [7:0] d,
    input logic [7:0] i, input logic g);
    wr <= 1'b1;
    addr <= REG_CMD;
    wdata <= {11'h000, g, i, c, d};
    @(posedge core_clk);
    wr <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic rdReg(input logic [3:0] a, output logic [31:0] v);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge core_clk);
  endtask
  task automatic waitHop(input int lim, output logic h);
    logic [7:0] c;
    c = link.curChannel;
    h = 1'b0;
    for (int k = 0; k < lim && !h; k++) begin
      @(posedge core_clk);
      h = (link.curChannel !== c);
    end
  endtask
  function automatic logic [31:0] freqOf(input logic [7:0] i,
    input logic [23:0] f, input logic [15:0] s, input logic [7:0] c);
    return {5'h00, i, 19'h00000} + 32'(f) + 32'(s) * 32'(c);
  endfunction
  // ----
  // tests
  // ----
  initial begin
    logic [31:0] v;
    logic [31:0] ex;
    logic [7:0] iv, ch;
    logic [7:0] e [4];
    logic [7:0] sq [4];
    logic [23:0] fr;
    logic [15:0] st, dv;
    logic h, t0;
    logic [4:0] dd [5] = '{5'h18, 5'h0C, 5'h0A, 5'h08, 5'h04};
    logic [7:0] cc [7] = '{8'h09, 8'h09, 8'h1A, 8'h0A, 8'h1C, 8'h1C, 8'h1B};
    logic [6:0] sg = 7'b1000010;
    logic [6:0] pf = 7'b0110000;
    logic [6:0] sf = 7'b0100000;
    logic [6:0] xh = 7'b0010101;
    v = $urandom(32'h3a957e9b);
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    cmp(32'(outputDivider), 32'h18);
    rdReg(REG_STATUS, v);
    cmp(v, 32'h0);
    rdReg(4'h7, v);
    cmp(v, 32'h0);
    $display("test reset done");
    for (int b = 0; b < 5; b++) begin
      cmd(CMD_BAND, 8'(b), 8'h00, 1'b0);
      cmp(32'(outputDivider), 32'(dd[b]));
    end
    $display("test band done");
    iv = 8'($urandom);
    fr = {5'h01, 19'($urandom)};
    st = 16'($urandom);
    ch = 8'($urandom_range(1, 254));
    dv = 16'($urandom);
    cmd(CMD_SET_INT, iv, 8'h00, 1'b0);
    cmd(CMD_SET_FRAC_HI, fr[23:16], 8'h00, 1'b0);
    cmd(CMD_SET_FRAC_MID, fr[15:8], 8'h00, 1'b0);
    cmd(CMD_SET_FRAC_LO, fr[7:0], 8'h00, 1'b0);
    cmd(CMD_STEP_HI, st[15:8], 8'h00, 1'b0);
    cmd(CMD_STEP_LO, st[7:0], 8'h00, 1'b0);
    cmd(CMD_START_TX, ch, 8'h00, 1'b1);
    ex = freqOf(iv, fr, st, ch);
    rdReg(REG_FREQ, v);
    cmp(v, ex);
    cmp(32'(integerDivideValue), 32'(ex[26:19]));
    txDeviation <= dv;
    repeat (4) @(posedge core_clk);
    cmp(32'(fractionDivideValue), 32'(19'(ex[18:0] + 19'(signed'(dv)))));
    txDeviation <= 16'h0000;
    cmd(CMD_START_TX, 8'h00, 8'h00, 1'b0);
    rdReg(REG_STATUS, v);
    cmp(v, {22'h0, 2'h2, ch});
    $display("test frequency done");
    cmd(CMD_IDLE, 8'h00, 8'h00, 1'b0);
    cmd(CMD_RSSI_LIMIT, 8'h80, 8'h00, 1'b0);
    cmd(CMD_WAIT_LIMIT, 8'h02, 8'h00, 1'b0);
    cmd(CMD_TABLE_SIZE, 8'h04, 8'h00, 1'b0);
    // distinct entries so that every hop shows on the channel
    for (int k = 0; k < 4; k++) begin
      e[k] = (k == 1) ? 8'hFF : 8'(k * 60 + $urandom_range(0, 50));
      cmd(CMD_TABLE_ENTRY, e[k], 8'(k), 1'b0);
    end
    sq = '{e[2], e[3], e[0], e[2]};
    signalStrength <= 8'($urandom_range(0, 127));
    // preamble timeout paces hops; strength alone hops every cycle
    cmd(CMD_HOP_CTRL, 8'h3A, 8'h00, 1'b0);
    cmd(CMD_START_RX, e[0], 8'h00, 1'b1);
    for (int k = 0; k < 4; k++) begin
      t0 = hopToggle;
      waitHop(3000, h);
      repeat (3) @(posedge core_clk);
      cmp(32'(link.curChannel), 32'(sq[k]));
      cmp(32'(hopToggle), 32'(t0 ^ (k != 2)));
    end
    $display("test sequence done");
    for (int k = 0; k < 7; k++) begin
      cmd(CMD_IDLE, 8'h00, 8'h00, 1'b0);
      cmd(CMD_HOP_CTRL, cc[k], 8'h00, 1'b0);
      signalStrength <= sg[k] ? 8'($urandom_range(128, 255)) :
        8'($urandom_range(0, 127));
      preambleFound <= pf[k];
      syncFound <= sf[k];
      cmd(CMD_START_RX, e[0], 8'h00, 1'b1);
      waitHop(1500, h);
      cmp(32'(h), 32'(xh[k]));
    end
    $display("test conditions done");
    test_done();
  end
endmodule
`default_nettype wire
